/* rtl/scan_port_regs.vh */
// constants for the boundary-scan test port: instruction codes, identity layout, controller state codes
// assumes inclusion by bare name from the port's design files
`ifndef SCAN_PORT_REGS_VH
`define SCAN_PORT_REGS_VH
`define IR_WIDTH        4
`define INS_EXTEST      4'h0
`define INS_SAMPLE      4'h1
`define INS_IDCODE      4'h2
`define INS_CLAMP       4'h3
`define INS_FLOAT       4'h4
`define INS_BYPASS      4'hf
`define IR_CAPTURE_VAL  4'h1
`define ID_WIDTH        32
`define ID_REVISION     4'h0
`define ID_PRESENT      1'h1
// state codes of the sixteen-state controller
`define ST_RESET        4'hf
`define ST_IDLE         4'hc
`define ST_SEL_DR       4'h7
`define ST_CAP_DR       4'h6
`define ST_SHIFT_DR     4'h2
`define ST_EXIT1_DR     4'h1
`define ST_PAUSE_DR     4'h3
`define ST_EXIT2_DR     4'h0
`define ST_UPD_DR       4'h5
`define ST_SEL_IR       4'h4
`define ST_CAP_IR       4'he
`define ST_SHIFT_IR     4'ha
`define ST_EXIT1_IR     4'h9
`define ST_PAUSE_IR     4'hb
`define ST_EXIT2_IR     4'h8
`define ST_UPD_IR       4'hd
`endif

/* rtl/scan_tap_fsm.v */
// sixteen-state test controller, advanced on a one-cycle test clock rise strike
// assumes tckRise and tmsIn are already synchronised to sys_clk
`timescale 1ns/10ps
`include "scan_port_regs.vh"
module scan_tap_fsm (
	input  wire       sys_clk,
	input  wire       reset_n,
	input  wire       tapReset,
	input  wire       tckRise,
	input  wire       tmsIn,
	output reg  [3:0] tapState_q
);
	reg [3:0] tapState_d;

	always @* begin
		tapState_d = tapState_q;
		case (tapState_q)
			`ST_RESET:    tapState_d = tmsIn ? `ST_RESET : `ST_IDLE;
			`ST_IDLE:     tapState_d = tmsIn ? `ST_SEL_DR : `ST_IDLE;
			`ST_SEL_DR:   tapState_d = tmsIn ? `ST_SEL_IR : `ST_CAP_DR;
			`ST_CAP_DR:   tapState_d = tmsIn ? `ST_EXIT1_DR : `ST_SHIFT_DR;
			`ST_SHIFT_DR: tapState_d = tmsIn ? `ST_EXIT1_DR : `ST_SHIFT_DR;
			`ST_EXIT1_DR: tapState_d = tmsIn ? `ST_UPD_DR : `ST_PAUSE_DR;
			`ST_PAUSE_DR: tapState_d = tmsIn ? `ST_EXIT2_DR : `ST_PAUSE_DR;
			`ST_EXIT2_DR: tapState_d = tmsIn ? `ST_UPD_DR : `ST_SHIFT_DR;
			`ST_UPD_DR:   tapState_d = tmsIn ? `ST_SEL_DR : `ST_IDLE;
			`ST_SEL_IR:   tapState_d = tmsIn ? `ST_RESET : `ST_CAP_IR;
			`ST_CAP_IR:   tapState_d = tmsIn ? `ST_EXIT1_IR : `ST_SHIFT_IR;
			`ST_SHIFT_IR: tapState_d = tmsIn ? `ST_EXIT1_IR : `ST_SHIFT_IR;
			`ST_EXIT1_IR: tapState_d = tmsIn ? `ST_UPD_IR : `ST_PAUSE_IR;
			`ST_PAUSE_IR: tapState_d = tmsIn ? `ST_EXIT2_IR : `ST_PAUSE_IR;
			`ST_EXIT2_IR: tapState_d = tmsIn ? `ST_UPD_IR : `ST_SHIFT_IR;
			`ST_UPD_IR:   tapState_d = tmsIn ? `ST_SEL_DR : `ST_IDLE;
			default:      tapState_d = `ST_RESET;
		endcase
	end

	always @(posedge sys_clk) begin
		if (!reset_n || tapReset)
			tapState_q <= `ST_RESET;
		else if (tckRise)
			tapState_q <= tapState_d;
	end
endmodule // scan_tap_fsm

/* rtl/boundary_scan_test_port.v */
// boundary-scan test access port: pin sampling, instruction decode, scan paths, output control
// assumes the test pins arrive asynchronously and sys_clk is far faster than the test clock
`timescale 1ns/10ps
`include "scan_port_regs.vh"
module boundary_scan_test_port #(
	parameter                  CELL_COUNT = 8,
	parameter [15:0]           PART_CODE  = 16'h1234, // arbitrary value
	parameter [10:0]           MAKER_CODE = 11'h055   // arbitrary value
) (
	input  wire                  sys_clk,
	input  wire                  reset_n,
	input  wire                  testClk,
	input  wire                  testModeSel,
	input  wire                  testDataIn,
	input  wire                  testReset_n,
	output reg                   testDataOut,
	output reg                   testDataOutEn_n,
	input  wire [CELL_COUNT-1:0] coreOut,
	input  wire [CELL_COUNT-1:0] coreOutEn_n,
	input  wire [CELL_COUNT-1:0] padIn,
	output reg  [CELL_COUNT-1:0] padOut,
	output reg  [CELL_COUNT-1:0] padOutEn_n,
	output wire [CELL_COUNT-1:0] coreIn
);
	// chain layout: padIn cells, then output value cells, then output enable cells
	localparam CHAIN_LEN = 3 * CELL_COUNT;

	reg [1:0] tckSync_q;
	reg [1:0] tmsSync_q;
	reg [1:0] tdiSync_q;
	reg [1:0] trstSync_q;
	reg       tckLast_q;

	wire tckRise = tckSync_q[1] & ~tckLast_q;
	wire tckFall = ~tckSync_q[1] & tckLast_q;
	wire tms     = tmsSync_q[1];
	wire tdi     = tdiSync_q[1];
	wire tapRst  = ~trstSync_q[1];

	always @(posedge sys_clk) begin
		if (!reset_n) begin
			tckSync_q  <= 2'h0;
			tmsSync_q  <= 2'h3;
			tdiSync_q  <= 2'h3;
			trstSync_q <= 2'h0;
			tckLast_q  <= 1'h0;
		end else begin
			tckSync_q  <= {tckSync_q[0], testClk};
			tmsSync_q  <= {tmsSync_q[0], testModeSel};
			tdiSync_q  <= {tdiSync_q[0], testDataIn};
			trstSync_q <= {trstSync_q[0], testReset_n};
			tckLast_q  <= tckSync_q[1];
		end
	end

	wire [3:0] tapState;

	scan_tap_fsm tapFsm (
		.sys_clk    (sys_clk),
		.reset_n    (reset_n),
		.tapReset   (tapRst),
		.tckRise    (tckRise),
		.tmsIn      (tms),
		.tapState_q (tapState)
	);

	reg [`IR_WIDTH-1:0]  irShift_q;
	reg [`IR_WIDTH-1:0]  irActive_q;
	reg                  bypass_q;
	reg [`ID_WIDTH-1:0]  idShift_q;
	reg [CHAIN_LEN-1:0]  chainShift_q;
	reg [CHAIN_LEN-1:0]  chainHold_q;

	wire inReset = (tapState == `ST_RESET);

	// which serial path and output pin mode the active instruction selects
	wire selChain = (irActive_q == `INS_EXTEST) || (irActive_q == `INS_SAMPLE);
	wire selId    = (irActive_q == `INS_IDCODE);
	wire forceOut = (irActive_q == `INS_EXTEST) || (irActive_q == `INS_CLAMP);
	wire floatOut = (irActive_q == `INS_FLOAT);

	wire [`ID_WIDTH-1:0] idValue = {`ID_REVISION, PART_CODE, MAKER_CODE, `ID_PRESENT};

	// parallel capture of pins and core-side drive
	wire [CHAIN_LEN-1:0] chainCapture = {coreOutEn_n, coreOut, padIn};

	always @(posedge sys_clk) begin
		if (!reset_n) begin
			irShift_q    <= `IR_CAPTURE_VAL;
			irActive_q   <= `INS_IDCODE;
			bypass_q     <= 1'h0;
			idShift_q    <= {`ID_WIDTH{1'h0}};
			chainShift_q <= {CHAIN_LEN{1'h0}};
			chainHold_q  <= {CHAIN_LEN{1'h1}};
		end else if (inReset) begin
			irActive_q <= `INS_IDCODE;
			irShift_q  <= `IR_CAPTURE_VAL;
		end else if (tckRise) begin
			case (tapState)
				`ST_CAP_IR:   irShift_q <= `IR_CAPTURE_VAL;
				`ST_SHIFT_IR: irShift_q <= {tdi, irShift_q[`IR_WIDTH-1:1]};
				`ST_UPD_IR:   irActive_q <= irShift_q;
				`ST_CAP_DR: begin
					bypass_q <= 1'h0;
					if (selId)
						idShift_q <= idValue;
					if (selChain)
						chainShift_q <= chainCapture;
				end
				`ST_SHIFT_DR: begin
					if (selChain)
						chainShift_q <= {tdi, chainShift_q[CHAIN_LEN-1:1]};
					else if (selId)
						idShift_q <= {tdi, idShift_q[`ID_WIDTH-1:1]};
					else
						bypass_q <= tdi;
				end
				`ST_UPD_DR: begin
					if (selChain)
						chainHold_q <= chainShift_q;
				end
				default: begin
				end
			endcase
		end
	end

	// serial out changes on the falling test clock edge
	reg serialBit;
	always @* begin
		if (tapState == `ST_SHIFT_IR)
			serialBit = irShift_q[0];
		else if (selChain)
			serialBit = chainShift_q[0];
		else if (selId)
			serialBit = idShift_q[0];
		else
			serialBit = bypass_q;
	end

	always @(posedge sys_clk) begin
		if (!reset_n) begin
			testDataOut     <= 1'h0;
			testDataOutEn_n <= 1'h1;
		end else if (tckFall) begin
			testDataOut     <= serialBit;
			testDataOutEn_n <= ~((tapState == `ST_SHIFT_IR) || (tapState == `ST_SHIFT_DR));
		end else if (inReset) begin
			testDataOutEn_n <= 1'h1;
		end
	end

	// output pins: normal, forced from held cells, or floated
	always @(posedge sys_clk) begin
		if (!reset_n) begin
			padOut     <= {CELL_COUNT{1'h0}};
			padOutEn_n <= {CELL_COUNT{1'h1}};
		end else if (floatOut) begin
			padOut     <= coreOut;
			padOutEn_n <= {CELL_COUNT{1'h1}};
		end else if (forceOut) begin
			padOut     <= chainHold_q[2*CELL_COUNT-1:CELL_COUNT];
			padOutEn_n <= chainHold_q[CHAIN_LEN-1:2*CELL_COUNT];
		end else begin
			padOut     <= coreOut;
			padOutEn_n <= coreOutEn_n;
		end
	end

	assign coreIn = padIn;
endmodule // boundary_scan_test_port

/* verification/scan_chk.sv */
// pin checks of the scan port
// assumes a bind onto the scan port top module
`timescale 1ns/10ps
module scan_chk #(parameter CELL_COUNT = 8) (
	input wire                  sys_clk,
	input wire                  reset_n,
	input wire                  testClk,
	input wire                  testReset_n,
	input wire                  testDataOut,
	input wire                  testDataOutEn_n,
	input wire [CELL_COUNT-1:0] coreOut,
	input wire [CELL_COUNT-1:0] coreOutEn_n,
	input wire [CELL_COUNT-1:0] padIn,
	input wire [CELL_COUNT-1:0] padOut,
	input wire [CELL_COUNT-1:0] padOutEn_n,
	input wire [CELL_COUNT-1:0] coreIn
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	sequence s_clkHigh; testClk[*3]; endsequence
	sequence s_trstHeld; !testReset_n[*6]; endsequence
	property p_rstOut; disable iff (1'b0) !reset_n |=> testDataOutEn_n && !testDataOut; endproperty
	property p_rstPad; disable iff (1'b0) !reset_n |=> (&padOutEn_n) && !(|padOut); endproperty
	property p_rstVal; $rose(reset_n) |-> testDataOutEn_n && (&padOutEn_n); endproperty
	property p_tdoFall; $changed(testDataOut) |-> !$past(testClk, 2); endproperty
	property p_tdoHold; s_clkHigh |-> $stable(testDataOut); endproperty
	property p_coreIn; coreIn == padIn; endproperty
	property p_trstOe; s_trstHeld |-> testDataOutEn_n; endproperty
	property p_trstPad; s_trstHeld |-> padOut == $past(coreOut) && padOutEn_n == $past(coreOutEn_n);
	endproperty
	a_rstOut: assert property (p_rstOut) else $error("serial out live in reset");
	a_rstPad: assert property (p_rstPad) else $error("pads live in reset");
	a_rstVal: assert property (p_rstVal) else $error("outputs moved at reset exit");
	a_tdoFall: assert property (p_tdoFall) else $error("serial out moved off fall");
	a_tdoHold: assert property (p_tdoHold) else $error("serial out moved while high");
	a_coreIn: assert property (p_coreIn) else $error("pad input not passed");
	a_trstOe: assert property (p_trstOe) else $error("serial out on in test reset");
	a_trstPad: assert property (p_trstPad) else $error("pads not normal in test reset");
endmodule // scan_chk

/* verification/ctrl_model.sv */
// external test controller model driving the serial test pins
// assumes 100 MHz sys_clk pacing; test clock rests low between frames
`timescale 1ns/10ps
module ctrl_model (
	input  wire  sys_clk,
	input  wire  testDataOut,
	output logic testClk,
	output logic testModeSel,
	output logic testDataIn,
	output logic testReset_n
);
	initial begin
		testClk = 1'b0;
		testModeSel = 1'b1;
		testDataIn = 1'b0;
		testReset_n = 1'b1;
	end
	// one 160 ns period; released data line shows the inverse
	task automatic tick(input logic m, input logic d, output logic o);
		@(posedge sys_clk) testModeSel <= m;
		testDataIn <= d;
		repeat (7) @(posedge sys_clk);
		o = testDataOut;
		testClk <= 1'b1;
		repeat (8) @(posedge sys_clk);
		testClk <= 1'b0;
		testDataIn <= ~d;
	endtask
	// idle to scan, n bits lsb first, update, back to idle
	task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
		logic o;
		dout = 32'h0;
		tick(1'b1, 1'b0, o);
		if (ir)
			tick(1'b1, 1'b0, o);
		tick(1'b0, 1'b0, o);
		tick(1'b0, 1'b0, o);
		for (int i = 0; i < n; i++) begin
			tick(i == n - 1, din[i], o);
			dout[i] = o;
		end
		tick(1'b1, 1'b0, o);
		tick(1'b0, 1'b0, o);
	endtask
	task automatic to_idle();
		logic o;
		repeat (5) tick(1'b1, 1'b0, o);
		tick(1'b0, 1'b0, o);
	endtask
	task automatic hold_reset();
		@(posedge sys_clk) testReset_n <= 1'b0;
		repeat (8) @(posedge sys_clk);
		testReset_n <= 1'b1;
		repeat (4) @(posedge sys_clk);
	endtask
endmodule // ctrl_model

/* verification/tb_top.sv */
// bench for the scan port: controller model on the test pins, bench holds core and pads
// assumes design files, checker and controller model compiled first
`timescale 1ns/10ps
`include "scan_port_regs.vh"
module tb_top;
	localparam [15:0] PC = 16'h5a3c; // arbitrary value
	localparam [10:0] MC = 11'h2c1;  // arbitrary value
	logic        sys_clk = 1'b0;
	logic        reset_n = 1'b0;
	logic [7:0]  coreOut = 8'h5a;
	logic [7:0]  coreOutEn_n = 8'hf0;
	logic [7:0]  padIn = 8'h3c;
	logic [31:0] o;
	wire         testClk, testModeSel, testDataIn, testReset_n, testDataOut, testDataOutEn_n;
	wire  [7:0]  padOut, padOutEn_n, coreIn;
	int          n_mismatch = 0;
	int          tests_run = 0;
	int          oeLow = 0;
	always #5 sys_clk = ~sys_clk;
	// sys_clk cycles with the serial out driven
	always @(posedge sys_clk)
		if (testDataOutEn_n == 1'b0)
			oeLow <= oeLow + 1;
	boundary_scan_test_port #(.PART_CODE(PC), .MAKER_CODE(MC)) boundary_scan_test_port_inst (
		.sys_clk, .reset_n, .testClk, .testModeSel, .testDataIn, .testReset_n, .testDataOut,
		.testDataOutEn_n, .coreOut, .coreOutEn_n, .padIn, .padOut, .padOutEn_n, .coreIn);
	ctrl_model ctrl_model_inst (.sys_clk, .testDataOut, .testClk, .testModeSel, .testDataIn,
		.testReset_n);
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic close_out();
		$display("mismatches %0d, comparisons %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic load(input logic [3:0] c);
		ctrl_model_inst.scan(1'b1, 4, {28'h0, c}, o);
		check(o[3:0], `IR_CAPTURE_VAL);
	endtask
	task automatic t_ident();
		int s;
		s = oeLow;
		ctrl_model_inst.scan(1'b0, 32, 32'h0, o);
		check(o, {`ID_REVISION, PC, MC, `ID_PRESENT});
		check(oeLow - s, 32'd512);
	endtask
	task automatic t_preload();
		load(`INS_SAMPLE);
		ctrl_model_inst.scan(1'b0, 24, 32'h0000a500, o);
		check(o[23:0], {coreOutEn_n, coreOut, padIn});
		load(`INS_EXTEST);
		check({padOutEn_n, padOut}, 16'h00a5);
	endtask
	task automatic t_codes();
		// only defined codes are issued
		logic [3:0]  code [4] = '{`INS_BYPASS, `INS_FLOAT, `INS_CLAMP, `INS_IDCODE};
		logic [7:0]  outs [4];
		logic [15:0] pads [4];
		outs = '{8'h2c, 8'h2c, 8'h2c, {MC[6:0], `ID_PRESENT}};
		pads = '{{coreOutEn_n, coreOut}, {8'hff, coreOut}, 16'h00a5, {coreOutEn_n, coreOut}};
		for (int i = 0; i < 4; i++) begin
			load(code[i]);
			ctrl_model_inst.scan(1'b0, 8, 32'h96, o);
			check(o[7:0], outs[i]);
			check({padOutEn_n, padOut}, pads[i]);
		end
	endtask
	task automatic t_testReset();
		load(`INS_CLAMP);
		check({padOutEn_n, padOut}, 16'h00a5);
		ctrl_model_inst.hold_reset();
		check({padOutEn_n, padOut}, {coreOutEn_n, coreOut});
		ctrl_model_inst.to_idle();
		t_ident();
	endtask
	initial begin
		#200000;
		n_mismatch++;
		close_out();
	end
	initial begin
		repeat (16) @(posedge sys_clk);
		reset_n <= 1'b1;
		repeat (4) @(posedge sys_clk);
		ctrl_model_inst.to_idle();
		t_ident();
		t_preload();
		t_codes();
		t_testReset();
		close_out();
	end
endmodule // tb_top
bind boundary_scan_test_port scan_chk #(.CELL_COUNT(CELL_COUNT)) scan_chk_inst (.sys_clk,
	.reset_n, .testClk, .testReset_n, .testDataOut, .testDataOutEn_n, .coreOut, .coreOutEn_n,
	.padIn, .padOut, .padOutEn_n, .coreIn);
